/* shl_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// RQ1: sync input active low when polarity invert set; toggling invert launches a sync.
// RQ2: with loop-1 option, outputs stay in sync until loop-1 lock detect is true.
// RQ3: with loop-2 option, sync stays engaged until loop-2 lock detect is true.
// RQ4: excluded output pairs keep running, untouched by any sync event.
// RQ5: host sets sync enable when syncing; always set in qualified-sync mode.
// RQ6: sync enable rising may sync; host protects outputs, must not rely on it.
// RQ7: with auto sync on, writing register words R0 to R5 launches a sync.
// RQ8: force-holdover enters holdover and powers the DAC regardless of holdover mode.
// RQ9: with tracking on, the DAC follows the loop-1 tuning voltage.
// RQ10: DAC updates at phase detector rate over divisor; host keeps it under 100 kHz.
// RQ11: host enables rail detect only with manual DAC on and auto mode 4 or 6.
// RQ12: holdover ends only after the exit count of in-window comparisons.
// RQ13: in holdover with manual DAC on, the DAC takes the manual value.
// RQ14: manual DAC readback returns the DAC value currently applied.
// RQ15: rail detect raises clock switch when tuning falls to low trip level.
// RQ16: rail detect raises clock switch when tuning rises to supply minus high trip.
// RQ17: with holdover mode on, any rail clock switch enters holdover.
// RQ18: loop-1 lock counter increments on each comparison inside the window.
// RQ19: loop-1 lock detect asserts once the counter reaches the lock count.
// RQ20: each reference has its own pre-divider ahead of the common loop-1 R divider.
// RQ21: in zero-delay modes outputs lead the input more as feedback delay grows.
// RQ22: status pins used as inputs are inverted when the invert bit is set.
// RQ23: an out-of-window comparison clears the lock counter and drops lock detect.
module shl_ctrl (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pdf_tick_in,
    input wire logic sync_pin_in,
    input wire logic sync_polarity_invert_in,
    input wire logic sync_enable_in,
    input wire logic sync_auto_enable_in,
    input wire logic qualified_sync_mode_in,
    input wire logic reg_write_in,
    input wire logic [shl_pkg::WADDR_W-1:0] reg_write_addr_in,
    input wire logic sync_until_loop1_lock_in,
    input wire logic sync_until_loop2_lock_in,
    input wire logic loop2_lock_in,
    input wire logic [shl_pkg::PAIRS-1:0] output_pair_sync_exclude_in,
    input wire logic compare_valid_in,
    input wire logic [shl_pkg::WIN_W-1:0] phase_error_in,
    input wire logic [shl_pkg::WIN_W-1:0] loop1_phase_window_in,
    input wire logic [shl_pkg::CNT_W-1:0] loop1_lock_count_in,
    input wire logic [shl_pkg::CNT_W-1:0] holdover_exit_count_in,
    input wire logic holdover_mode_in,
    input wire logic force_holdover_in,
    input wire logic track_enable_in,
    input wire logic manual_dac_enable_in,
    input wire logic [shl_pkg::DAC_W-1:0] manual_dac_value_in,
    input wire logic [shl_pkg::DAC_W-1:0] tune_code_in,
    input wire logic [shl_pkg::DIV_W-1:0] dac_clk_div_in,
    input wire logic tune_rail_detect_enable_in,
    input wire logic [shl_pkg::LVL_W-1:0] tune_level_in,
    input wire logic [shl_pkg::TRIP_W-1:0] tune_low_threshold_in,
    input wire logic [shl_pkg::TRIP_W-1:0] tune_high_threshold_in,
    input wire logic [1:0] ref_tick_in,
    input wire logic ref_active_in,
    input wire logic [shl_pkg::PRE_W-1:0] ref0_pre_divider_in,
    input wire logic [shl_pkg::PRE_W-1:0] ref1_pre_divider_in,
    input wire logic [shl_pkg::CNT_W-1:0] loop1_ref_divider_in,
    input wire logic fb_tick_in,
    input wire logic zero_delay_mode_in,
    input wire logic [shl_pkg::DLY_W-1:0] loop1_feedback_delay_in,
    input wire logic ref0_status_pin_in,
    input wire logic ref1_status_pin_in,
    input wire logic ref0_status_pin_type_in,
    input wire logic ref1_status_pin_type_in,
    input wire logic [1:0] ref0_status_pin_select_in,
    input wire logic [1:0] ref1_status_pin_select_in,
    input wire logic ref_status_invert_in,
    input wire logic [2:0] ref_selection_mode_in,
    output logic [shl_pkg::PAIRS-1:0] pair_sync_out,
    output logic sync_active_out,
    output logic loop1_lock_out,
    output logic holdover_out,
    output logic dac_power_out,
    output logic dac_update_out,
    output logic [shl_pkg::DAC_W-1:0] dac_value_out,
    output logic [shl_pkg::DAC_W-1:0] manual_dac_readback_out,
    output logic clock_switch_out,
    output logic loop1_ref_tick_out,
    output logic fb_delayed_tick_out,
    output logic ref0_status_pin_out,
    output logic ref0_status_pin_oe_out,
    output logic ref1_status_pin_out,
    output logic ref1_status_pin_oe_out,
    output logic [1:0] ref_select_sensed_out
);
    import shl_pkg::*;

    // zero divisor acts as one; shared by every divider
    function automatic logic div_wrap(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] div);
        logic [CNT_W-1:0] lim;
        lim = (div == CNT_RST) ? CNT_RST : div - CNT_ONE;
        return cnt >= lim;
    endfunction : div_wrap

    typedef struct packed {
        logic pol_prev;
        logic en_prev;
        logic sync_event;
        logic wait_l1;
        logic wait_l2;
        logic [PAIRS-1:0] pair_sync;
        logic [CNT_W-1:0] lock_cnt;
        logic lock;
        shl_hold_state_t hstate;
        logic [CNT_W-1:0] exit_cnt;
        logic [DIV_W-1:0] dac_div;
        logic dac_upd;
        logic [DAC_W-1:0] dac;
        logic low_prev;
        logic high_prev;
        logic clk_switch;
        logic [CNT_W-1:0] pre0;
        logic [CNT_W-1:0] pre1;
        logic [CNT_W-1:0] rdiv;
        logic ref_tick;
        logic [DLY_W-1:0] dly;
        logic fb_tick;
        logic st0;
        logic st1;
    } shl_state_t;

    shl_state_t st;
    shl_state_t next_st;

    function automatic logic stat_pick(input logic [1:0] sel);
        case (sel)
            STAT_LOW: return 1'b0;
            STAT_LOCK: return st.lock;
            STAT_HOLD: return st.hstate == SHL_HOLD;
            STAT_SWITCH: return st.clk_switch;
            default: return 1'b0;
        endcase
    endfunction : stat_pick

    logic sync_level;
    logic in_window;
    logic low_trip;
    logic high_trip;
    logic auto_write;
    logic [LVL_W-1:0] high_level;
    logic pre_tick;
    logic hold_exit;
    logic [1:0] sensed;

    always_comb begin
        sync_level = sync_pin_in ^ sync_polarity_invert_in; // RQ1
        in_window = phase_error_in < loop1_phase_window_in;
        auto_write = reg_write_in && (reg_write_addr_in <= AUTO_SYNC_LAST_WORD);
        high_level = RAIL_STEPS - {1'b0, tune_high_threshold_in};
        low_trip = tune_rail_detect_enable_in
            && (tune_level_in <= {1'b0, tune_low_threshold_in}); // RQ15
        high_trip = tune_rail_detect_enable_in && (tune_level_in >= high_level); // RQ16
        sensed[0] = ref0_status_pin_in ^ ref_status_invert_in; // RQ22
        sensed[1] = ref1_status_pin_in ^ ref_status_invert_in; // RQ22
        pre_tick = 1'b0;
        hold_exit = 1'b0;
        next_st = st;

        // sync sources; enable must be high for any of them to reach outputs
        next_st.pol_prev = sync_polarity_invert_in;
        next_st.en_prev = sync_enable_in;
        next_st.sync_event = sync_enable_in && (
            (sync_polarity_invert_in != st.pol_prev) // RQ1
            || (sync_auto_enable_in && auto_write) // RQ7
            || (sync_enable_in && !st.en_prev)); // RQ6
        if (sync_until_loop1_lock_in && (sync_level || st.sync_event)) begin
            next_st.wait_l1 = 1'b1;
        end else if (st.lock || !sync_until_loop1_lock_in) begin
            next_st.wait_l1 = 1'b0; // RQ2
        end
        if (sync_until_loop2_lock_in && (sync_level || st.sync_event)) begin
            next_st.wait_l2 = 1'b1;
        end else if (loop2_lock_in || !sync_until_loop2_lock_in) begin
            next_st.wait_l2 = 1'b0; // RQ3
        end
        next_st.pair_sync = {PAIRS{sync_enable_in && (sync_level || st.sync_event
            || st.wait_l1 || st.wait_l2)}} & ~output_pair_sync_exclude_in; // RQ4

        // loop-1 lock detect on each phase comparison
        if (compare_valid_in) begin
            if (in_window) begin
                if (st.lock_cnt != {CNT_W{1'b1}}) begin
                    next_st.lock_cnt = st.lock_cnt + CNT_ONE; // RQ18
                end
            end else begin
                next_st.lock_cnt = CNT_RST; // RQ23
            end
        end
        next_st.lock = next_st.lock_cnt >= loop1_lock_count_in; // RQ19

        // rail trips are edge events so a parked tuning voltage fires once
        next_st.low_prev = low_trip;
        next_st.high_prev = high_trip;
        next_st.clk_switch = (low_trip && !st.low_prev) || (high_trip && !st.high_prev);

        // holdover
        case (st.hstate)
            SHL_TRACK: begin
                next_st.exit_cnt = CNT_RST;
                if (force_holdover_in) begin
                    next_st.hstate = SHL_HOLD; // RQ8
                end else if (holdover_mode_in && st.clk_switch) begin
                    next_st.hstate = SHL_HOLD; // RQ17
                end
            end
            SHL_HOLD: begin
                if (compare_valid_in) begin
                    if (in_window) begin
                        if (st.exit_cnt != {CNT_W{1'b1}}) begin
                            next_st.exit_cnt = st.exit_cnt + CNT_ONE; // RQ12
                        end
                    end else begin
                        next_st.exit_cnt = CNT_RST;
                    end
                end
                hold_exit = !force_holdover_in && !(holdover_mode_in && st.clk_switch)
                    && (st.exit_cnt >= holdover_exit_count_in); // RQ12
                if (hold_exit) begin
                    next_st.hstate = SHL_TRACK;
                end
            end
            default: begin
                next_st.hstate = SHL_TRACK;
                next_st.exit_cnt = CNT_RST;
            end
        endcase

        // DAC update divider on the phase detector rate
        next_st.dac_upd = 1'b0;
        if (pdf_tick_in) begin
            if (div_wrap(CNT_W'(st.dac_div), CNT_W'(dac_clk_div_in))) begin
                next_st.dac_div = DIV_RST;
                next_st.dac_upd = 1'b1; // RQ10
            end else begin
                next_st.dac_div = st.dac_div + DIV_ONE;
            end
        end
        if (st.hstate == SHL_HOLD) begin
            if (manual_dac_enable_in) begin
                next_st.dac = manual_dac_value_in; // RQ13
            end
        end else if (track_enable_in && st.dac_upd) begin
            next_st.dac = tune_code_in; // RQ9
        end

        // per-reference pre-divider then shared R divider
        next_st.ref_tick = 1'b0;
        if (ref_tick_in[0] && !ref_active_in) begin
            if (div_wrap(st.pre0, CNT_W'(ref0_pre_divider_in))) begin
                next_st.pre0 = CNT_RST;
                pre_tick = 1'b1; // RQ20
            end else begin
                next_st.pre0 = st.pre0 + CNT_ONE;
            end
        end
        if (ref_tick_in[1] && ref_active_in) begin
            if (div_wrap(st.pre1, CNT_W'(ref1_pre_divider_in))) begin
                next_st.pre1 = CNT_RST;
                pre_tick = 1'b1; // RQ20
            end else begin
                next_st.pre1 = st.pre1 + CNT_ONE;
            end
        end
        if (pre_tick) begin
            if (div_wrap(st.rdiv, loop1_ref_divider_in)) begin
                next_st.rdiv = CNT_RST;
                next_st.ref_tick = 1'b1;
            end else begin
                next_st.rdiv = st.rdiv + CNT_ONE;
            end
        end

        // holding back feedback makes the loop pull outputs earlier
        next_st.fb_tick = 1'b0;
        if (fb_tick_in) begin
            if (!zero_delay_mode_in || loop1_feedback_delay_in == DLY_RST) begin
                next_st.fb_tick = 1'b1;
                next_st.dly = DLY_RST;
            end else begin
                next_st.dly = loop1_feedback_delay_in; // RQ21
            end
        end else if (st.dly != DLY_RST) begin
            next_st.dly = st.dly - DLY_ONE;
            next_st.fb_tick = st.dly == DLY_ONE; // RQ21
        end

        next_st.st0 = stat_pick(ref0_status_pin_select_in);
        next_st.st1 = stat_pick(ref1_status_pin_select_in);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
            st.hstate <= SHL_TRACK;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        pair_sync_out = st.pair_sync;
        sync_active_out = |st.pair_sync;
        loop1_lock_out = st.lock;
        holdover_out = st.hstate == SHL_HOLD;
        dac_power_out = force_holdover_in || track_enable_in
            || (st.hstate == SHL_HOLD); // RQ8
        dac_update_out = st.dac_upd;
        dac_value_out = st.dac;
        manual_dac_readback_out = st.dac; // RQ14
        clock_switch_out = st.clk_switch;
        loop1_ref_tick_out = st.ref_tick;
        fb_delayed_tick_out = st.fb_tick;
        ref0_status_pin_out = st.st0;
        ref1_status_pin_out = st.st1;
        ref0_status_pin_oe_out = !ref0_status_pin_type_in;
        ref1_status_pin_oe_out = !ref1_status_pin_type_in;
        // sensed selection only counts in the pin-driven modes
        ref_select_sensed_out = ((ref_selection_mode_in == MODE_PIN_SEL)
            || (ref_selection_mode_in == MODE_AUTO_PIN))
            ? (sensed & {ref1_status_pin_type_in, ref0_status_pin_type_in}) : 2'h0;
    end
endmodule : shl_ctrl

/* shl_pkg.sv */
package shl_pkg;
    localparam int CNT_W = 14;
    localparam int DAC_W = 10;
    localparam int WIN_W = 8;
    localparam int TRIP_W = 6;
    localparam int LVL_W = 7;
    localparam int PAIRS = 6;
    localparam int DIV_W = 10;
    localparam int PRE_W = 3;
    localparam int DLY_W = 6;
    localparam int WADDR_W = 5;
    // rail levels counted in 50 mV steps; 3.3 V supply is 66 steps
    localparam logic [LVL_W-1:0] RAIL_STEPS = 7'h42;
    // register words that launch an automatic sync: R0..R5
    localparam logic [WADDR_W-1:0] AUTO_SYNC_LAST_WORD = 5'h05;
    localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
    localparam logic [DAC_W-1:0] DAC_RST = 10'h000;
    localparam logic [DIV_W-1:0] DIV_RST = 10'h000;
    localparam logic [DIV_W-1:0] DIV_ONE = 10'h001;
    localparam logic [DLY_W-1:0] DLY_RST = 6'h00;
    localparam logic [DLY_W-1:0] DLY_ONE = 6'h01;
    localparam logic [2:0] MODE_PIN_SEL = 3'h3;
    localparam logic [2:0] MODE_AUTO_A = 3'h4;
    localparam logic [2:0] MODE_AUTO_PIN = 3'h6;
    // status pin output selections
    localparam logic [1:0] STAT_LOW = 2'h0;
    localparam logic [1:0] STAT_LOCK = 2'h1;
    localparam logic [1:0] STAT_HOLD = 2'h2;
    localparam logic [1:0] STAT_SWITCH = 2'h3;

    typedef enum logic [1:0] {
        SHL_TRACK = 2'b01,
        SHL_HOLD = 2'b10
    } shl_hold_state_t;
endpackage : shl_pkg

/* shl_ctrl_chk.sv */
`timescale 1ns/1ps
module shl_ctrl_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sync_enable_in,
    input wire logic sync_auto_enable_in,
    input wire logic reg_write_in,
    input wire logic [shl_pkg::WADDR_W-1:0] reg_write_addr_in,
    input wire logic [shl_pkg::PAIRS-1:0] output_pair_sync_exclude_in,
    input wire logic compare_valid_in,
    input wire logic [shl_pkg::WIN_W-1:0] phase_error_in,
    input wire logic [shl_pkg::WIN_W-1:0] loop1_phase_window_in,
    input wire logic [shl_pkg::CNT_W-1:0] loop1_lock_count_in,
    input wire logic force_holdover_in,
    input wire logic holdover_mode_in,
    input wire logic manual_dac_enable_in,
    input wire logic [shl_pkg::DAC_W-1:0] manual_dac_value_in,
    input wire logic [shl_pkg::PAIRS-1:0] pair_sync_out,
    input wire logic loop1_lock_out,
    input wire logic holdover_out,
    input wire logic dac_power_out,
    input wire logic [shl_pkg::DAC_W-1:0] dac_value_out,
    input wire logic [shl_pkg::DAC_W-1:0] manual_dac_readback_out,
    input wire logic clock_switch_out
);
    import shl_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_excl;
        $stable(output_pair_sync_exclude_in) |-> (pair_sync_out & output_pair_sync_exclude_in) == '0;
    endproperty
    a_excl: assert property (p_excl) else $error("excluded pair synced");
    property p_auto;
        reg_write_in && sync_enable_in && sync_auto_enable_in && reg_write_addr_in <= 5'h05
            ##1 sync_enable_in && output_pair_sync_exclude_in == '0 |-> ##1 pair_sync_out == '1;
    endproperty
    a_auto: assert property (p_auto) else $error("auto sync missing");
    // event pipeline is two deep, so three idle cycles clear it
    property p_en;
        (!sync_enable_in) [*3] |-> pair_sync_out == '0;
    endproperty
    a_en: assert property (p_en) else $error("sync while disabled");
    property p_miss;
        compare_valid_in && phase_error_in >= loop1_phase_window_in && loop1_lock_count_in != '0
            |-> ##[1:2] !loop1_lock_out;
    endproperty
    a_miss: assert property (p_miss) else $error("lock kept after miss");
    property p_force;
        force_holdover_in [*2] |-> holdover_out && dac_power_out;
    endproperty
    a_force: assert property (p_force) else $error("force holdover ignored");
    property p_man;
        holdover_out && manual_dac_enable_in |=> dac_value_out == $past(manual_dac_value_in);
    endproperty
    a_man: assert property (p_man) else $error("manual dac not applied");
    property p_rdbk;
        manual_dac_readback_out == dac_value_out;
    endproperty
    a_rdbk: assert property (p_rdbk) else $error("readback differs");
    property p_sw;
        clock_switch_out && holdover_mode_in |=> holdover_out;
    endproperty
    a_sw: assert property (p_sw) else $error("switch without holdover");
endmodule : shl_ctrl_chk
bind shl_ctrl shl_ctrl_chk chk_u (.*);

/* shl_host_model.sv */
`timescale 1ns/1ps
module shl_host_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic use_sync_in,
    input wire logic qualified_sync_mode_in,
    input wire logic want_rail_in,
    input wire logic manual_dac_enable_in,
    input wire logic [2:0] ref_selection_mode_in,
    input wire logic wr_go_in,
    input wire logic [shl_pkg::WADDR_W-1:0] wr_addr_in,
    output logic sync_enable_out,
    output logic rail_enable_out,
    output logic reg_write_out,
    output logic [shl_pkg::WADDR_W-1:0] reg_write_addr_out
);
    import shl_pkg::*;
    logic [WADDR_W-1:0] last_addr;
    assign sync_enable_out = use_sync_in | qualified_sync_mode_in;
    assign rail_enable_out = want_rail_in & manual_dac_enable_in
        & (ref_selection_mode_in == MODE_AUTO_A || ref_selection_mode_in == MODE_AUTO_PIN);
    assign reg_write_out = wr_go_in;
    // idle address flips each cycle so a stale word never looks valid
    assign reg_write_addr_out = wr_go_in ? wr_addr_in : ~last_addr;
    always_ff @(posedge clk_in) begin
        last_addr <= rst_n_in ? reg_write_addr_out : 5'h00;
    end
endmodule : shl_host_model

/* sync_holdover_lock_detect_ctrl_test.sv */
`timescale 1ns/1ps
module sync_holdover_lock_detect_ctrl_test;
    import shl_pkg::*;
    logic clk_in, rst_n_in, pdf_tick_in, sync_pin_in, sync_polarity_invert_in, sync_auto_enable_in;
    logic qualified_sync_mode_in, sync_until_loop1_lock_in, sync_until_loop2_lock_in, loop2_lock_in;
    logic compare_valid_in, holdover_mode_in, force_holdover_in, track_enable_in, manual_dac_enable_in;
    logic ref_active_in, fb_tick_in, zero_delay_mode_in, ref0_status_pin_in, ref1_status_pin_in;
    logic ref0_status_pin_type_in, ref1_status_pin_type_in, ref_status_invert_in;
    logic use_sync, want_rail, wr_go, sync_active_out, loop1_lock_out, holdover_out, dac_power_out;
    logic dac_update_out, clock_switch_out, loop1_ref_tick_out, fb_delayed_tick_out;
    logic ref0_status_pin_out, ref0_status_pin_oe_out, ref1_status_pin_out, ref1_status_pin_oe_out;
    logic [1:0] ref_tick_in, ref0_status_pin_select_in, ref1_status_pin_select_in;
    logic [1:0] ref_select_sensed_out;
    logic [2:0] ref_selection_mode_in, ref0_pre_divider_in, ref1_pre_divider_in;
    logic [PAIRS-1:0] output_pair_sync_exclude_in, pair_sync_out, ex;
    logic [WIN_W-1:0] phase_error_in, loop1_phase_window_in;
    logic [CNT_W-1:0] loop1_lock_count_in, holdover_exit_count_in, loop1_ref_divider_in;
    logic [DAC_W-1:0] manual_dac_value_in, tune_code_in, dac_value_out, manual_dac_readback_out, mv;
    logic [DIV_W-1:0] dac_clk_div_in;
    logic [LVL_W-1:0] tune_level_in;
    logic [TRIP_W-1:0] tune_low_threshold_in, tune_high_threshold_in;
    logic [DLY_W-1:0] loop1_feedback_delay_in;
    logic [WADDR_W-1:0] wr_addr;
    wire logic sync_enable_in, tune_rail_detect_enable_in, reg_write_in;
    wire logic [WADDR_W-1:0] reg_write_addr_in;
    int mismatches = 0, n_checks = 0, upd_cnt = 0, sw_cnt = 0, k, n;
    shl_host_model host_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .use_sync_in(use_sync),
        .qualified_sync_mode_in(qualified_sync_mode_in), .want_rail_in(want_rail),
        .manual_dac_enable_in(manual_dac_enable_in), .ref_selection_mode_in(ref_selection_mode_in),
        .wr_go_in(wr_go), .wr_addr_in(wr_addr), .sync_enable_out(sync_enable_in),
        .rail_enable_out(tune_rail_detect_enable_in), .reg_write_out(reg_write_in),
        .reg_write_addr_out(reg_write_addr_in));
    shl_ctrl dut_u (.*);
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        upd_cnt <= upd_cnt + int'(dac_update_out);
        sw_cnt <= sw_cnt + int'(clock_switch_out);
    end
    task automatic tick(input int c);
        repeat (c) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a);
        wr_go = 1'b1;
        wr_addr = a;
        tick(1);
        wr_go = 1'b0;
        tick(1);
    endtask : wr
    task automatic cmp(input int c, input bit hit);
        repeat (c) begin
            compare_valid_in = 1'b1;
            phase_error_in = hit ? 8'($urandom % 128) : 8'(128 + $urandom % 128);
            tick(1);
        end
        compare_valid_in = 1'b0;
    endtask : cmp
    function automatic logic [9:0] sense();
        logic m;
        m = ref_selection_mode_in == MODE_PIN_SEL || ref_selection_mode_in == MODE_AUTO_PIN;
        return {6'h00, m & ref1_status_pin_type_in & (ref1_status_pin_in ^ ref_status_invert_in),
            m & ref0_status_pin_type_in & (ref0_status_pin_in ^ ref_status_invert_in),
            ~ref0_status_pin_type_in, ~ref1_status_pin_type_in};
    endfunction : sense
    task automatic print_verdict;
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // background inputs churn every cycle
    initial begin
        forever begin
            tick(1);
            pdf_tick_in = ~pdf_tick_in;
            {loop1_ref_divider_in, ref_tick_in, ref_active_in, fb_tick_in} = 18'($urandom);
            {ref0_pre_divider_in, ref1_pre_divider_in, zero_delay_mode_in, loop1_feedback_delay_in,
                ref0_status_pin_select_in, ref1_status_pin_select_in} = 17'($urandom);
        end
    end
    initial begin
        void'($urandom(32'h737b0a74));
        {rst_n_in, sync_pin_in, sync_polarity_invert_in, sync_auto_enable_in, qualified_sync_mode_in,
            sync_until_loop1_lock_in, sync_until_loop2_lock_in, loop2_lock_in,
            output_pair_sync_exclude_in, compare_valid_in, phase_error_in, holdover_mode_in,
            force_holdover_in, track_enable_in, manual_dac_enable_in, manual_dac_value_in,
            tune_code_in, dac_clk_div_in, ref0_status_pin_in, ref1_status_pin_in,
            ref0_status_pin_type_in, ref1_status_pin_type_in, ref_status_invert_in,
            ref_selection_mode_in, use_sync, want_rail, wr_go, wr_addr} = '0;
        pdf_tick_in = 1'b1;
        loop1_phase_window_in = 8'h80;
        loop1_lock_count_in = 14'(2 + $urandom % 8);
        holdover_exit_count_in = 14'h0003;
        tune_level_in = 7'h21;
        tune_low_threshold_in = 6'h05;
        tune_high_threshold_in = 6'h05;
        tick(16);
        chk(10'({pair_sync_out, holdover_out, loop1_lock_out, clock_switch_out}), 10'h000);
        rst_n_in = 1'b1;
        ex = 6'($urandom);
        output_pair_sync_exclude_in = ~ex;
        sync_auto_enable_in = 1'b1;
        use_sync = 1'b1;
        tick(2);
        chk(10'(pair_sync_out), 10'(ex));
        tick(2);
        for (k = 0; k < 8; k++) begin
            ex = k ? 6'($urandom) : 6'h3f;
            output_pair_sync_exclude_in = ~ex;
            wr(5'(k));
            chk(10'({sync_active_out, pair_sync_out}), k <= 5 ? 10'({|ex, ex}) : 10'h000);
            tick(2);
        end
        sync_polarity_invert_in = 1'b1;
        sync_pin_in = 1'b1;
        tick(2);
        chk(10'(pair_sync_out), 10'(ex));
        tick(2);
        chk(10'(pair_sync_out), 10'h000);
        sync_pin_in = 1'b0;
        tick(3);
        chk(10'(pair_sync_out), 10'(ex));
        sync_pin_in = 1'b1;
        tick(3);
        chk(10'(pair_sync_out), 10'h000);
        cmp(1, 0);
        cmp(int'(loop1_lock_count_in) - 1, 1);
        tick(3);
        chk(10'(loop1_lock_out), 10'h000);
        cmp(1, 1);
        tick(3);
        chk(10'(loop1_lock_out), 10'h001);
        cmp(1, 0);
        tick(3);
        chk(10'(loop1_lock_out), 10'h000);
        for (k = 0; k < 2; k++) begin
            cmp(1, 0);
            loop2_lock_in = 1'b0;
            {sync_until_loop2_lock_in, sync_until_loop1_lock_in} = 2'(k + 1);
            wr(5'h00);
            tick(6);
            chk(10'(pair_sync_out), 10'(ex));
            if (k == 0)
                cmp(int'(loop1_lock_count_in), 1);
            else
                loop2_lock_in = 1'b1;
            tick(4);
            chk(10'(pair_sync_out), 10'h000);
        end
        {sync_until_loop2_lock_in, sync_until_loop1_lock_in} = 2'b00;
        mv = 10'($urandom);
        manual_dac_value_in = mv;
        manual_dac_enable_in = 1'b1;
        force_holdover_in = 1'b1;
        tick(3);
        chk(10'({holdover_out, dac_power_out}), 10'h003);
        chk(manual_dac_readback_out, mv);
        force_holdover_in = 1'b0;
        cmp(1, 0);
        cmp(2, 1);
        tick(3);
        chk(10'(holdover_out), 10'h001);
        cmp(1, 1);
        tick(3);
        chk(10'(holdover_out), 10'h000);
        holdover_mode_in = 1'b1;
        ref_selection_mode_in = MODE_AUTO_A;
        want_rail = 1'b1;
        for (k = 0; k < 2; k++) begin
            tune_level_in = k ? 7'h3c : 7'h06;
            tick(4);
            n = sw_cnt;
            chk(10'(holdover_out), 10'h000);
            tune_level_in = k ? 7'h3d : 7'h05;
            tick(4);
            chk(10'(sw_cnt - n), 10'h001);
            chk(10'(holdover_out), 10'h001);
            tune_level_in = 7'h21;
            cmp(1, 0);
            cmp(3, 1);
            tick(3);
        end
        want_rail = 1'b0;
        track_enable_in = 1'b1;
        manual_dac_enable_in = 1'b0;
        tune_code_in = 10'($urandom);
        dac_clk_div_in = 10'h190;
        tick(6);
        n = upd_cnt;
        tick(1600);
        chk(10'(upd_cnt - n), 10'h002);
        chk(dac_value_out, tune_code_in);
        for (k = 0; k < 16; k++) begin
            ref_selection_mode_in = 3'(k);
            {ref0_status_pin_in, ref1_status_pin_in, ref0_status_pin_type_in,
                ref1_status_pin_type_in, ref_status_invert_in} = 5'($urandom);
            tick(1);
            chk(10'({ref_select_sensed_out, ref0_status_pin_oe_out, ref1_status_pin_oe_out}),
                sense());
        end
        qualified_sync_mode_in = 1'b1;
        use_sync = 1'b0;
        wr(5'h01);
        chk(10'(pair_sync_out), 10'(ex));
        qualified_sync_mode_in = 1'b0;
        tick(3);
        wr(5'h01);
        chk(10'(pair_sync_out), 10'h000);
        print_verdict();
    end
endmodule : sync_holdover_lock_detect_ctrl_test
